//--- lit_interval_timer.sv
// Long interval timer: time base, interval counter, registers and interrupt.
// Assumes a single-cycle register port on mclk and a level power-down input.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module lit_interval_timer #(
	parameter int TICK_CYCLES = lit_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// System
	input wire logic power_down,
	output logic irq,
	output logic wake_req,
	output logic [15:0] wake_vector,
	output logic interval_hit_flag
);
	import lit_pkg::*;

	localparam int PS_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	localparam logic [PS_W-1:0] PS_LAST = PS_W'(TICK_CYCLES - 1);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [PS_W-1:0] presc;
		logic time_base_enable;
		logic interval_count_enable;
		logic interval_hit_flag;
		logic single_shot;
		lit_unit_type unit;
		logic [7:0] interval_compare_value;
		logic [7:0] icnt;
		logic [7:0] status;
		logic [7:0] mask;
		logic [7:0] rdata;
		logic wake;
		logic irq;
	} lit_state_type;

	lit_state_type st_ff;
	lit_state_type nxt_st;

	logic tick;
	logic sec_step;
	logic min_step;
	logic hour_step;
	logic unit_step;
	logic hit;
	logic wr_ctl;
	logic wr_hth;
	logic wr_sec;
	logic wr_min;
	logic wr_hour;
	logic [7:0] hth_cnt;
	logic [7:0] sec_cnt;
	logic [7:0] min_cnt;
	logic [7:0] hour_cnt;
	logic [7:0] ctl_read;

	// ****************************************************************
	// Time base
	// ****************************************************************
	// The prescaler stands in for the slow oscillator and is never gated by power-down
	assign tick = st_ff.time_base_enable && (st_ff.presc == PS_LAST);

	assign wr_ctl = reg_wr && (reg_addr == OFS_INTERVAL_TIMER_CONTROL);
	assign wr_hth = reg_wr && (reg_addr == OFS_SUB_SECOND_COUNT);
	assign wr_sec = reg_wr && (reg_addr == OFS_SECONDS_COUNT);
	assign wr_min = reg_wr && (reg_addr == OFS_MINUTES_COUNT);
	assign wr_hour = reg_wr && (reg_addr == OFS_HOURS_COUNT);

	lit_wrap_counter #(
		.WIDTH(8),
		.MAX_VAL(SUB_SECOND_MAX)
	) u_sub_second (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.step(tick),
		.load(wr_hth),
		.load_data(reg_wdata),
		.count(hth_cnt),
		.wrap(sec_step)
	);

	lit_wrap_counter #(
		.WIDTH(8),
		.MAX_VAL(SECONDS_MAX)
	) u_seconds (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.step(sec_step),
		.load(wr_sec),
		.load_data(reg_wdata),
		.count(sec_cnt),
		.wrap(min_step)
	);

	lit_wrap_counter #(
		.WIDTH(8),
		.MAX_VAL(MINUTES_MAX)
	) u_minutes (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.step(min_step),
		.load(wr_min),
		.load_data(reg_wdata),
		.count(min_cnt),
		.wrap(hour_step)
	);

	lit_wrap_counter #(
		.WIDTH(8),
		.MAX_VAL(HOURS_MAX)
	) u_hours (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.step(hour_step),
		.load(wr_hour),
		.load_data(reg_wdata),
		.count(hour_cnt),
		.wrap()
	);

	// ****************************************************************
	// Interval counter clock select
	// ****************************************************************
	always_comb
	begin
		case (st_ff.unit)
			UNIT_SUB_SECOND: unit_step = tick;
			UNIT_SECOND: unit_step = sec_step;
			UNIT_MINUTE: unit_step = min_step;
			UNIT_HOUR: unit_step = hour_step;
			default: unit_step = 1'b0;
		endcase
	end

	// Match is judged on the value the counter is about to take
	assign hit = st_ff.interval_count_enable && unit_step
		&& ((st_ff.icnt + 8'h01) == st_ff.interval_compare_value);

	assign ctl_read = {2'b00, st_ff.unit[1], st_ff.unit[0], st_ff.single_shot,
		st_ff.interval_hit_flag, st_ff.interval_count_enable, st_ff.time_base_enable};

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		nxt_st = st_ff;

		// Prescaler restarts whenever the time base is off
		if (!st_ff.time_base_enable || st_ff.presc == PS_LAST)
		begin
			nxt_st.presc = '0;
		end
		else
		begin
			nxt_st.presc = st_ff.presc + 1'b1;
		end

		// Interval counter steps on the selected unit
		if (st_ff.interval_count_enable && unit_step)
		begin
			nxt_st.icnt = st_ff.icnt + 8'h01;
		end

		// Software writes
		if (wr_ctl)
		begin
			nxt_st.time_base_enable = reg_wdata[BIT_TIME_BASE_ENABLE];
			nxt_st.interval_count_enable = reg_wdata[BIT_INTERVAL_COUNT_ENABLE];
			nxt_st.single_shot = reg_wdata[BIT_SINGLE_SHOT];
			nxt_st.unit = lit_unit_type'({reg_wdata[BIT_INTERVAL_UNIT_SELECT_HI],
				reg_wdata[BIT_INTERVAL_UNIT_SELECT_LO]});
			// Writing zero clears the hit flag; writing one leaves it
			if (!reg_wdata[BIT_INTERVAL_HIT_FLAG])
			begin
				nxt_st.interval_hit_flag = 1'b0;
			end
		end
		if (reg_wr && reg_addr == OFS_INTERVAL_COMPARE_VALUE)
		begin
			nxt_st.interval_compare_value = reg_wdata;
		end
		if (reg_wr && reg_addr == OFS_EVENT_STATUS)
		begin
			nxt_st.status = st_ff.status & ~reg_wdata;
		end
		if (reg_wr && reg_addr == OFS_EVENT_MASK)
		begin
			nxt_st.mask = reg_wdata;
		end

		// Hardware events come after the writes so a set beats a clear
		if (hit)
		begin
			nxt_st.interval_hit_flag = 1'b1;
			nxt_st.status[EVT_INTERVAL_MATCH] = 1'b1;
			nxt_st.icnt = 8'h00;
			if (st_ff.single_shot)
			begin
				nxt_st.interval_count_enable = 1'b0;
			end
		end
		if (sec_step)
		begin
			nxt_st.status[EVT_SECOND] = 1'b1;
		end

		// Disabled interval counter holds at zero
		if (!nxt_st.interval_count_enable)
		begin
			nxt_st.icnt = 8'h00;
		end

		nxt_st.irq = |(nxt_st.status & nxt_st.mask);
		// Wake only on an enabled interval match while powered down
		nxt_st.wake = power_down && nxt_st.status[EVT_INTERVAL_MATCH]
			&& nxt_st.mask[EVT_INTERVAL_MATCH];

		// Read data: single domain, so every count is read whole
		nxt_st.rdata = 8'h00;
		if (reg_rd)
		begin
			if (reg_addr == OFS_INTERVAL_TIMER_CONTROL)
			begin
				nxt_st.rdata = ctl_read;
			end
			else if (reg_addr == OFS_SUB_SECOND_COUNT)
			begin
				nxt_st.rdata = hth_cnt;
			end
			else if (reg_addr == OFS_SECONDS_COUNT)
			begin
				nxt_st.rdata = sec_cnt;
			end
			else if (reg_addr == OFS_MINUTES_COUNT)
			begin
				nxt_st.rdata = min_cnt;
			end
			else if (reg_addr == OFS_HOURS_COUNT)
			begin
				nxt_st.rdata = hour_cnt;
			end
			else if (reg_addr == OFS_INTERVAL_COMPARE_VALUE)
			begin
				nxt_st.rdata = st_ff.interval_compare_value;
			end
			else if (reg_addr == OFS_EVENT_STATUS)
			begin
				nxt_st.rdata = st_ff.status;
			end
			else if (reg_addr == OFS_EVENT_MASK)
			begin
				nxt_st.rdata = st_ff.mask;
			end
			else
			begin
				nxt_st.rdata = 8'h00;
			end
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata = st_ff.rdata;
	assign irq = st_ff.irq;
	assign wake_req = st_ff.wake;
	assign wake_vector = TIMER_INT_VECTOR;
	assign interval_hit_flag = st_ff.interval_hit_flag;

endmodule // lit_interval_timer

//--- lit_pkg.sv
// Constants, offsets, field positions and types of the long interval timer.
// Assumes a 10 MHz core clock; the 1/128 s tick is derived from it.
package lit_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 100;
	// One sub-second step is 1/128 s
	localparam int TICK_PERIOD_NS = 7812500;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] OFS_INTERVAL_TIMER_CONTROL = 8'hA1;
	localparam logic [7:0] OFS_SUB_SECOND_COUNT = 8'hA2;
	localparam logic [7:0] OFS_SECONDS_COUNT = 8'hA3;
	localparam logic [7:0] OFS_MINUTES_COUNT = 8'hA4;
	localparam logic [7:0] OFS_HOURS_COUNT = 8'hA5;
	localparam logic [7:0] OFS_INTERVAL_COMPARE_VALUE = 8'hA6;
	localparam logic [7:0] OFS_EVENT_STATUS = 8'hA7;
	localparam logic [7:0] OFS_EVENT_MASK = 8'hA8;

	// ****************************************************************
	// Control register fields
	// ****************************************************************
	localparam int BIT_TIME_BASE_ENABLE = 0;
	localparam int BIT_INTERVAL_COUNT_ENABLE = 1;
	localparam int BIT_INTERVAL_HIT_FLAG = 2;
	localparam int BIT_SINGLE_SHOT = 3;
	localparam int BIT_INTERVAL_UNIT_SELECT_LO = 4;
	localparam int BIT_INTERVAL_UNIT_SELECT_HI = 5;

	// ****************************************************************
	// Event status and mask fields
	// ****************************************************************
	localparam int EVT_INTERVAL_MATCH = 0;
	localparam int EVT_SECOND = 1;

	// ****************************************************************
	// Reset values and limits
	// ****************************************************************
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_INTERVAL_COMPARE = 8'h00;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] SUB_SECOND_MAX = 8'h7F;
	localparam logic [7:0] SECONDS_MAX = 8'h3B;
	localparam logic [7:0] MINUTES_MAX = 8'h3B;
	localparam logic [7:0] HOURS_MAX = 8'h17;
	localparam logic [15:0] TIMER_INT_VECTOR = 16'h0053;

	// ****************************************************************
	// Interval unit select
	// ****************************************************************
	typedef enum logic [1:0] {
		UNIT_SUB_SECOND = 2'b00,
		UNIT_SECOND = 2'b01,
		UNIT_MINUTE = 2'b10,
		UNIT_HOUR = 2'b11
	} lit_unit_type;

endpackage

//--- lit_wrap_counter.sv
// One time-base stage: counts 0..MAX_VAL on each step and flags the wrap.
// Assumes step and load never need queuing; a load wins over a step.
`timescale 1ns/1ps
module lit_wrap_counter #(
	parameter int WIDTH = 8,
	parameter logic [7:0] MAX_VAL = 8'h3B
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Control
	input wire logic step,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_data,
	// Result
	output logic [WIDTH-1:0] count,
	output logic wrap
);
	import lit_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] cnt;
	} lit_stage_type;

	lit_stage_type stage_ff;
	lit_stage_type nxt_stage;
	logic at_max;

	// Values above the limit written by software still wrap to zero
	assign at_max = (stage_ff.cnt >= MAX_VAL[WIDTH-1:0]);
	assign wrap = step && at_max && !load;
	assign count = stage_ff.cnt;

	always_comb
	begin
		nxt_stage = stage_ff;
		if (load)
		begin
			nxt_stage.cnt = load_data;
		end
		else if (step)
		begin
			if (at_max)
			begin
				nxt_stage.cnt = '0;
			end
			else
			begin
				nxt_stage.cnt = stage_ff.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			stage_ff <= '0;
		end
		else
		begin
			stage_ff <= nxt_stage;
		end
	end

endmodule // lit_wrap_counter

//--- lit_chk.sv
// Port checker of the long interval timer.
// Assumes it is bound to lit_interval_timer and sees only its ports.
`timescale 1ns/1ps
module lit_chk
	import lit_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// System
	input wire logic power_down,
	input wire logic irq,
	input wire logic wake_req,
	input wire logic [15:0] wake_vector,
	input wire logic interval_hit_flag
);
	// ****************************************************************
	// Shadow of the mask and of hit flag clears
	// ****************************************************************
	logic [1:0] mask_ff;
	logic [1:0] clr_ff;
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			mask_ff <= 2'b00;
			clr_ff <= 2'b00;
		end
		else
		begin
			if (reg_wr && reg_addr == OFS_EVENT_MASK)
				mask_ff <= reg_wdata[1:0];
			clr_ff <= {clr_ff[0],
				reg_wr && reg_addr == OFS_INTERVAL_TIMER_CONTROL && !reg_wdata[2]};
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	property p_vec;
		wake_vector == 16'h0053;
	endproperty
	a_vec: assert property (p_vec)
		else $error("wake vector wrong");
	property p_idle;
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_idle: assert property (p_idle)
		else $error("read data outside read slot");
	property p_ctrl;
		reg_rd && reg_addr == OFS_INTERVAL_TIMER_CONTROL |=> reg_rdata[7:6] == 2'b00;
	endproperty
	a_ctrl: assert property (p_ctrl)
		else $error("control high bits not zero");
	property p_unmap;
		reg_rd && (reg_addr < 8'hA1 || reg_addr > 8'hA8) |=> reg_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");
	property p_wake;
		wake_req |-> irq && $past(power_down);
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake without cause");
	property p_fall;
		$fell(interval_hit_flag) |-> clr_ff != 2'b00;
	endproperty
	a_fall: assert property (p_fall)
		else $error("hit flag dropped by itself");
	property p_irqm;
		irq |-> (mask_ff | $past(mask_ff)) != 2'b00;
	endproperty
	a_irqm: assert property (p_irqm)
		else $error("interrupt while masked");
	property p_hit;
		$rose(interval_hit_flag) && mask_ff[0] |-> ##[0:2] irq;
	endproperty
	a_hit: assert property (p_hit)
		else $error("no interrupt on match");
endmodule // lit_chk
bind lit_interval_timer lit_chk u_chk (.mclk, .sys_rst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .power_down, .irq, .wake_req, .wake_vector,
	.interval_hit_flag);

//--- lit_interval_timer_test.sv
// Self-checking test of the long interval timer through its register port.
// Assumes the tick is cut to 4 cycles, so one second is 512 cycles.
`timescale 1ns/1ps
module lit_interval_timer_test;
	import lit_pkg::*;
	localparam int TC = 4;
	logic mclk, sys_rst, reg_wr, reg_rd, power_down;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic irq, wake_req, interval_hit_flag;
	logic [15:0] wake_vector;
	int fails, checks, n, e;
	lit_interval_timer #(.TICK_CYCLES(TC)) dut (.mclk, .sys_rst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .power_down, .irq,
		.wake_req, .wake_vector, .interval_hit_flag);
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic end_of_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		chk(16'(reg_rdata), 16'(d));
	endtask
	task automatic wait_hit();
		n = 0;
		while (interval_hit_flag !== 1'b1)
		begin
			@(negedge mclk);
			n++;
			if (n > 40000)
			begin
				fails++;
				end_of_test();
			end
		end
	endtask
	task automatic t_regs();
		rc(8'hA1, 8'h00);
		rc(8'hA6, 8'h00);
		rc(8'hA7, 8'h00);
		wr(8'hA6, 8'hFF);
		rc(8'hA6, 8'hFF);
		wr(8'hB0, 8'h5A);
		rc(8'hB0, 8'h00);
		wr(8'hA1, 8'hF4);
		rc(8'hA1, 8'h30);
		wr(8'hA1, 8'h00);
		$display("register test done");
	endtask
	task automatic t_base();
		wr(8'hA2, 8'h7E);
		wr(8'hA3, 8'h3B);
		wr(8'hA4, 8'h3B);
		wr(8'hA5, 8'h17);
		wr(8'hA8, 8'h02);
		wr(8'hA1, 8'h01);
		repeat (2 * TC + 1) @(posedge mclk);
		wr(8'hA1, 8'h00);
		rc(8'hA2, 8'h00);
		rc(8'hA3, 8'h00);
		rc(8'hA4, 8'h00);
		rc(8'hA5, 8'h00);
		chk(16'(irq), 16'h0001);
		wr(8'hA7, 8'h02);
		repeat (3 * TC) @(negedge mclk);
		chk(16'(irq), 16'h0000);
		rc(8'hA2, 8'h00);
		$display("time base test done");
	endtask
	task automatic t_units();
		wr(8'hA6, 8'h01);
		for (int u = 0; u < 4; u++)
		begin
			wr(8'hA2, 8'h00);
			wr(8'hA3, (u == 3) ? 8'h3B : 8'h00);
			wr(8'hA4, (u == 3) ? 8'h3B : 8'h00);
			wr(8'hA1, {2'b00, 2'(u), 4'hB});
			wait_hit();
			e = (u == 0) ? TC : (u == 2) ? 7680 * TC : 128 * TC;
			chk(16'(n >= e - 3 && n <= e + 3), 16'h0001);
			rc(8'hA1, {2'b00, 2'(u), 4'hD});
			repeat (2 * TC) @(negedge mclk);
			chk(16'(interval_hit_flag), 16'h0001);
			wr(8'hA1, 8'h00);
		end
		$display("unit test done");
	endtask
	task automatic t_cont();
		wr(8'hA7, 8'hFF);
		wr(8'hA8, 8'h01);
		wr(8'hA6, 8'h02);
		power_down <= 1'b1;
		wr(8'hA1, 8'h03);
		wait_hit();
		repeat (2) @(negedge mclk);
		chk(16'(irq), 16'h0001);
		chk(16'(wake_req), 16'h0001);
		chk(wake_vector, 16'h0053);
		rc(8'hA1, 8'h07);
		wr(8'hA1, 8'h00);
		repeat (4 * TC) @(negedge mclk);
		chk(16'(interval_hit_flag), 16'h0000);
		wr(8'hA1, 8'h03);
		wait_hit();
		chk(16'(n >= 2 * TC), 16'h0001);
		wr(8'hA8, 8'h00);
		repeat (2) @(negedge mclk);
		chk(16'(irq), 16'h0000);
		chk(16'(wake_req), 16'h0000);
		wr(8'hA1, 8'h00);
		power_down <= 1'b0;
		wr(8'hA8, 8'h01);
		repeat (2) @(negedge mclk);
		chk(16'(irq), 16'h0001);
		chk(16'(wake_req), 16'h0000);
		wr(8'hA7, 8'h03);
		rc(8'hA7, 8'h00);
		$display("continuous test done");
	endtask
	initial
	begin
		fails = 0;
		checks = 0;
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		power_down = 1'b0;
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		t_regs();
		t_base();
		t_units();
		t_cont();
		end_of_test();
	end
endmodule // lit_interval_timer_test
